// ==== design/pcm_line_supervision.sv ====
/*
 * PCM receive framing supervision, mismatch report capture and
 * decode, reinit request status, with an APB register slave.
 * Assumes frame_sync_pulse is launched on pcm_bit_clock, the mismatch
 * report arrives on pclk, and configuration is static while running.
 */
// How it works
// RULE1 - Slot code decodes per mode, modulo slots
// RULE2 - Software sets pair0 enable for comparison
// RULE3 - System finds faulty line by test pattern
// RULE4 - Count bit clocks per frame, compare expected
// RULE5 - Two good frames in row give sync
// RULE6 - One bad frame drops sync
// RULE7 - Every sync change sets framing change flag
// RULE8 - Event register read clears framing flag
// RULE9 - Status read changes nothing, raises nothing
// RULE10 - Sync flag low on mismatch or mode0
// RULE11 - Long frame sync period leaves flag low
// RULE12 - Reinit flag set only by spikes
// RULE13 - Software polls reinit flag, reinitialises
// RULE14 - Partner drives double bit clock at 2048k
// RULE15 - Enabled pair mismatch sets mismatch flag
// RULE16 - Next mismatch waits for report read
// RULE17 - Report bit 7 pair, 6:0 code
// RULE18 - Double rate doubles expected clock count
`timescale 1ns/100ps
module pcm_line_supervision
	import pcm_sup_pkg::*;
#(
	parameter int CNT_W = 10    // Frame clock counter width
) (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// PCM link
	input  wire logic        pcm_bit_clock,
	input  wire logic        frame_sync_pulse,
	// Comparison datapath report, pclk domain
	input  wire logic        mismatch_valid,
	input  wire mismatch_s   mismatch_in,
	// Supply and clock spike detector, asynchronous
	input  wire logic        spike_detect,
	// Status outputs
	output logic             sync_state_flag
);

	// Counter must hold twice the largest frame of 256 bits
	if (CNT_W < 10) begin : g_cnt_w_check
		$error("CNT_W too small for a 512 clock frame");
	end

	// ============================================================
	// Helper functions

	// Expected clocks per frame from bit count and rate
	function automatic logic [CNT_W-1:0] expect_clocks(input logic [7:0] bits,
		input logic dbl);
		logic [CNT_W-1:0] n;
		n = CNT_W'({1'b0, bits}) + CNT_W'(1);
		// RULE18 double rate doubles
		expect_clocks = dbl ? CNT_W'(n << 1) : n;
	endfunction

	// Timeslot number from a report code, pcm mode and bit count
	function automatic logic [7:0] decode_slot(input logic [1:0] mode,
		input logic [6:0] code, input logic [7:0] bits);
		logic [8:0] raw;
		logic [5:0] slot_count;
		raw = 9'h000;
		slot_count = 6'(({1'b0, bits} + 9'h001) >> 3);
		case (mode)
			2'b10:         raw = {2'b00, code} + {1'b0, SLOT_OFS_M2};
			2'b01, 2'b11:  raw = {3'b000, code[6:1]} + {1'b0, SLOT_OFS_M1};
			default:       raw = {4'b0000, code[6:2]} + {1'b0, SLOT_OFS_M0};
		endcase
		// Guard a zero slot count so the modulo stays defined
		decode_slot = (slot_count == 6'h00) ? raw[7:0] : 8'(raw % {3'b000, slot_count});
	endfunction

	// Highest bit number of the mismatching group
	function automatic logic [2:0] decode_bit(input logic [1:0] mode,
		input logic [6:0] code);
		case (mode)
			2'b10:         decode_bit = 3'h7;
			2'b01, 2'b11:  decode_bit = code[0] ? 3'h3 : 3'h7;
			default:       decode_bit = 3'h7 - {code[1:0], 1'b0};
		endcase
	endfunction

	// ============================================================
	// Software registers and pclk state
	logic [7:0]  pcm_mode_q;        // pcm_mode_register
	logic [7:0]  op_mode_q;         // operating_mode_register
	logic [7:0]  bits_frame_q;      // bits_per_frame_setting
	logic        framing_change_q;  // framing_change_flag
	logic        mismatch_flag_q;   // input_mismatch_flag
	logic        mismatch_armed_q;  // New mismatch allowed
	mismatch_s   report_q;          // mismatch_report
	logic [10:0] location_q;        // Decoded slot and top bit
	logic        reinit_q;          // reinit_request_flag
	logic [1:0]  spike_sync_q;      // Spike detector synchroniser
	logic [1:0]  sync_in_q;         // Link sync level synchroniser
	logic        sync_seen_q;       // Last seen effective sync flag
	logic        link_sync_q;       // Sync level from the link side
	logic [31:0] prdata_q;          // Read data

	// ============================================================
	// APB decode
	wire         setup_phase = psel & ~penable;
	wire         access      = psel & penable;
	wire [7:0]   reg_ofs     = paddr[7:0];
	wire         hit_mode    = (reg_ofs == OFS_PCM_MODE);
	wire         hit_op      = (reg_ofs == OFS_OP_MODE);
	wire         hit_bits    = (reg_ofs == OFS_BITS_FRAME);
	wire         hit_events  = (reg_ofs == OFS_EVENTS);
	wire         hit_status  = (reg_ofs == OFS_SUP_STATUS);
	wire         hit_report  = (reg_ofs == OFS_MISMATCH);
	wire         hit_version = (reg_ofs == OFS_VERSION);
	wire         hit_loc     = (reg_ofs == OFS_LOCATION);
	wire         mapped      = (paddr[31:8] == 24'h000000) & (paddr[1:0] == 2'b00) &
	                           (hit_mode | hit_op | hit_bits | hit_events |
	                           hit_status | hit_report | hit_version | hit_loc);
	wire         wr_ok       = access & pwrite & mapped;
	wire         rd_ok       = access & ~pwrite & mapped;
	wire         rd_events   = rd_ok & hit_events;
	wire         rd_report   = rd_ok & hit_report;

	// RULE10 flag forced low while operating mode bit 0 is clear
	wire         sync_now    = sync_in_q[1] & op_mode_q[SUPERVISE_EN_POS];
	// RULE7 both directions of change count
	wire         sync_change = sync_now ^ sync_seen_q;

	// RULE15 only enabled pairs report
	wire         pair_enabled = mismatch_in.pair ? pcm_mode_q[PAIR1_EN_POS]
	                                             : pcm_mode_q[PAIR0_EN_POS];
	// RULE16 capture only while armed
	wire         take_report = mismatch_valid & pair_enabled & mismatch_armed_q;
	wire [1:0]   pcm_mode    = pcm_mode_q[MODE_HI_POS:MODE_LO_POS];

	// Read mux; status bits other than the sync flag keep reset value
	wire [7:0]   status_val  = (RST_SUP_STATUS & ~(8'h01 << SYNC_FLAG_POS)) |
	                           (8'({sync_now}) << SYNC_FLAG_POS);
	wire [7:0]   events_val  = (8'({framing_change_q}) << EV_FRAMING_POS) |
	                           (8'({mismatch_flag_q}) << EV_MISMATCH_POS);
	wire [31:0]  rd_mux      =
		hit_mode    ? {24'h000000, pcm_mode_q} :
		hit_op      ? {24'h000000, op_mode_q} :
		hit_bits    ? {24'h000000, bits_frame_q} :
		hit_events  ? {24'h000000, events_val} :
		hit_status  ? {24'h000000, status_val} :
		hit_report  ? {24'h000000, report_q} :
		hit_version ? {16'h0000, VERSION_CODE, 7'h00, reinit_q} :
		hit_loc     ? {21'h000000, location_q} : 32'h00000000;

	// Zero wait states; read data sampled in the setup cycle
	assign pready          = 1'b1;
	assign pslverr         = access & ~mapped;
	assign prdata          = prdata_q;
	assign sync_state_flag = sync_seen_q;

	// ============================================================
	// Configuration registers; RULE2 compare enables written here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcm_mode_q   <= RST_ZERO;
			op_mode_q    <= RST_ZERO;
			bits_frame_q <= RST_ZERO;
		end else if (wr_ok) begin
			if (hit_mode) pcm_mode_q <= pwdata[7:0];
			if (hit_op)   op_mode_q <= pwdata[7:0];
			if (hit_bits) bits_frame_q <= pwdata[7:0];
		end
	end

	// Read data latch; RULE9 status read has no side effect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (setup_phase) begin
			prdata_q <= rd_mux;
		end
	end

	// Framing change flag and sync tracking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_in_q        <= 2'b00;
			sync_seen_q      <= 1'b0;
			framing_change_q <= 1'b0;
		end else begin
			sync_in_q        <= {sync_in_q[0], link_sync_q};
			sync_seen_q      <= sync_now;
			// RULE7 set on change, set wins over clear
			// RULE8 event register read clears it
			framing_change_q <= sync_change | (framing_change_q & ~rd_events);
		end
	end

	// Mismatch flag, report capture and decode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mismatch_flag_q  <= 1'b0;
			mismatch_armed_q <= 1'b1;
			report_q         <= '0;
			location_q       <= 11'h000;
		end else begin
			// RULE15 set on capture, set wins over the read clear
			mismatch_flag_q <= take_report | (mismatch_flag_q & ~rd_events);
			// RULE16 disarm on capture, rearm on report read
			if (take_report) begin
				mismatch_armed_q <= 1'b0;
			end else if (rd_report) begin
				mismatch_armed_q <= 1'b1;
			end
			if (take_report) begin
				// RULE17 pair in bit 7, code in 6:0
				report_q   <= mismatch_in;
				// RULE1 slot and bit group decode
				location_q <= {decode_bit(pcm_mode, mismatch_in.code),
				               decode_slot(pcm_mode, mismatch_in.code, bits_frame_q)};
			end
		end
	end

	// Reinit request, sticky until reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spike_sync_q <= 2'b00;
			reinit_q     <= 1'b0;
		end else begin
			spike_sync_q <= {spike_sync_q[0], spike_detect};
			// RULE12 only the spike detector sets it
			reinit_q     <= reinit_q | spike_sync_q[1];
		end
	end

	// ============================================================
	// Link domain on pcm_bit_clock
	logic [1:0]       lrst_q;       // Reset release synchroniser
	logic [1:0]       fs_sync_q;    // Frame sync input stages
	logic             fs_prev_q;    // For rising edge detect
	logic [8:0]       cfg_a_q;      // Config stage 1 {rate, bits}
	logic [8:0]       cfg_b_q;      // Config stage 2
	logic [8:0]       cfg_c_q;      // Config stage 3, for the settle check
	logic [8:0]       cfg_use_q;    // Config in use by the counter
	logic [CNT_W-1:0] clk_cnt_q;    // Clocks since last frame sync
	logic             seen_fs_q;    // A frame start has been seen
	sync_state_e      state_q;      // Supervision state

	wire              lrst_n   = lrst_q[1];
	wire              fs_edge  = fs_sync_q[1] & ~fs_prev_q;
	wire [CNT_W-1:0]  expected = expect_clocks(cfg_use_q[7:0], cfg_use_q[8]);
	// RULE4 period is count plus the frame sync cycle
	wire              frame_ok = seen_fs_q & (clk_cnt_q + CNT_W'(1) == expected);
	wire              cnt_full = &clk_cnt_q;

	// Reset synchroniser: async assert, clocked release
	always_ff @(posedge pcm_bit_clock or negedge presetn) begin
		if (!presetn) begin
			lrst_q <= 2'b00;
		end else begin
			lrst_q <= {lrst_q[0], 1'b1};
		end
	end

	// Input stages; config word crosses two stages, then a settle check
	always_ff @(posedge pcm_bit_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			fs_sync_q <= 2'b00;
			fs_prev_q <= 1'b0;
			cfg_a_q   <= 9'h000;
			cfg_b_q   <= 9'h000;
			cfg_c_q   <= 9'h000;
			cfg_use_q <= 9'h000;
		end else begin
			fs_sync_q <= {fs_sync_q[0], frame_sync_pulse};
			fs_prev_q <= fs_sync_q[1];
			cfg_a_q   <= {pcm_mode_q[RATE_POS], bits_frame_q};
			cfg_b_q   <= cfg_a_q;
			cfg_c_q   <= cfg_b_q;
			// Bits of a changing word may land a cycle apart; take it once steady
			cfg_use_q <= (cfg_b_q == cfg_c_q) ? cfg_b_q : cfg_use_q;
		end
	end

	// RULE4 clock counter, saturating on long periods
	always_ff @(posedge pcm_bit_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			clk_cnt_q <= '0;
			seen_fs_q <= 1'b0;
		end else if (fs_edge) begin
			clk_cnt_q <= '0;
			seen_fs_q <= 1'b1;
		end else if (!cnt_full) begin
			clk_cnt_q <= clk_cnt_q + CNT_W'(1);
		end
	end

	// Sync state machine, judged once per frame sync
	always_ff @(posedge pcm_bit_clock or negedge lrst_n) begin
		if (!lrst_n) begin
			state_q     <= ST_HUNT;
			link_sync_q <= 1'b0;
		end else begin
			link_sync_q <= (state_q == ST_SYNC);
			if (fs_edge) begin
				case (state_q)
					// RULE5 two good frames in a row
					ST_HUNT: state_q <= frame_ok ? ST_ONE : ST_HUNT;
					ST_ONE:  state_q <= frame_ok ? ST_SYNC : ST_HUNT;
					// RULE6 RULE11 one bad or long frame drops sync
					ST_SYNC: state_q <= frame_ok ? ST_SYNC : ST_HUNT;
					default: state_q <= ST_HUNT;
				endcase
			end
		end
	end

endmodule // pcm_line_supervision

// ==== design/pcm_sup_pkg.sv ====
/*
 * Shared constants and types for the PCM line supervision block:
 * register offsets, field positions, reset values and the state codes
 * of the frame supervision machine.
 * Assumes a 32-bit APB master and a single register of at most 16 bits per word.
 */
package pcm_sup_pkg;

	// ============================================================
	// Register byte offsets
	localparam logic [7:0] OFS_PCM_MODE   = 8'h00; // pcm_mode_register
	localparam logic [7:0] OFS_OP_MODE    = 8'h04; // operating_mode_register
	localparam logic [7:0] OFS_BITS_FRAME = 8'h08; // bits_per_frame_setting
	localparam logic [7:0] OFS_EVENTS     = 8'h0c; // event_flags_register
	localparam logic [7:0] OFS_SUP_STATUS = 8'h10; // supervision_status
	localparam logic [7:0] OFS_MISMATCH   = 8'h14; // mismatch_report
	localparam logic [7:0] OFS_VERSION    = 8'h18; // version_status_register
	localparam logic [7:0] OFS_LOCATION   = 8'h1c; // decoded mismatch location

	// ============================================================
	// Field positions
	localparam int MODE_HI_POS    = 7;  // Pcm mode, bits 7:6
	localparam int MODE_LO_POS    = 6;
	localparam int RATE_POS       = 5;  // clock_rate_select
	localparam int PAIR1_EN_POS     = 1;  // Compare enable, lines two/three
	localparam int PAIR0_EN_POS     = 0;  // pair0_compare_enable
	localparam int SUPERVISE_EN_POS = 0;  // operating_mode_bit0
	localparam int EV_FRAMING_POS   = 3;  // framing_change_flag
	localparam int EV_MISMATCH_POS  = 2;  // input_mismatch_flag
	localparam int SYNC_FLAG_POS    = 5;  // sync_state_flag
	localparam int REINIT_POS       = 0;  // reinit_request_flag
	localparam int PAIR_POS       = 7;  // line_pair_indicator

	// ============================================================
	// Reset values
	localparam logic [7:0] RST_SUP_STATUS = 8'h05;
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] VERSION_CODE   = 8'h10; // Arbitrary value

	// ============================================================
	// Timeslot decode offsets per pcm mode
	localparam logic [7:0] SLOT_OFS_M2 = 8'h08;
	localparam logic [7:0] SLOT_OFS_M1 = 8'h04;
	localparam logic [7:0] SLOT_OFS_M0 = 8'h02;

	// ============================================================
	// Frame supervision states
	typedef enum logic [1:0] {
		ST_HUNT = 2'b00,   // No good frame seen
		ST_ONE  = 2'b01,   // One good frame seen
		ST_SYNC = 2'b10    // Synchronised
	} sync_state_e;

	// Mismatch report from the comparison datapath
	typedef struct packed {
		logic       pair;  // 0: lines zero/one, 1: lines two/three
		logic [6:0] code;  // Timeslot and bit code
	} mismatch_s;

endpackage

// ==== sim/pcm_backplane_model.sv ====
/* Backplane model: a free running bit clock and a frame sync pulse.
   Assumes the bench sets frame_len, the bit clocks per frame. */
`timescale 1ns/100ps
module pcm_backplane_model (
	// Frame length in bit clocks
	input  wire logic [11:0] frame_len,
	// Link outputs
	output logic             pcm_bit_clock,
	output logic             frame_sync_pulse
);
	int cnt_q = 0; // Position in frame
	// ==========================================================
	// bit clock rate
	// Phase offset keeps its edges apart from pclk edges
	initial begin
		pcm_bit_clock = 1'b0;
		#13;
		forever #32 pcm_bit_clock = ~pcm_bit_clock;
	end
	// any frame length
	// Sync pulse one bit clock wide at each frame start
	always @(posedge pcm_bit_clock) begin
		cnt_q <= (cnt_q + 1 >= int'(frame_len)) ? 0 : cnt_q + 1;
		frame_sync_pulse <= (cnt_q == 0);
	end
endmodule // pcm_backplane_model

// ==== sim/pcm_line_supervision_sva.sv ====
/* Checker: register reads against sync, event and spike history.
   Assumes it sees only the ports of the supervision block. */
`timescale 1ns/100ps
module pcm_line_supervision_sva
	import pcm_sup_pkg::*;
(
	// Clock, reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Side inputs and result
	input wire logic        mismatch_valid,
	input wire logic        spike_detect,
	input wire logic        sync_state_flag
);
	// ==========================================================
	// Decode and history
	wire       rd_su = psel && !penable && !pwrite; // Read setup
	wire       acc   = psel && penable;             // Access phase
	wire [7:0] ofs   = paddr[7:0];                  // Register offset
	logic [2:0] age_q;  // Cycles since spike, 7 = settled
	logic       pend_q; // Sync change not yet read out
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Ages 1 to 6 are not judged: the synchroniser sits there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			age_q <= 3'h0;
		else if (spike_detect)
			age_q <= (age_q == 3'h0) ? 3'h1 : age_q;
		else if (age_q != 3'h0 && age_q != 3'h7)
			age_q <= age_q + 3'h1;
	end
	// A read of events wins over a change seen at the same edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pend_q <= 1'b0;
		else if (acc && !pwrite && ofs == OFS_EVENTS)
			pend_q <= 1'b0;
		else if ($changed(sync_state_flag))
			pend_q <= 1'b1;
	end
	// ==========================================================
	// Properties
	property p_ev_clr; acc && !pwrite && ofs == OFS_EVENTS && !mismatch_valid
		##1 !psel && !mismatch_valid ##1 rd_su && ofs == OFS_EVENTS
		|=> !prdata[EV_MISMATCH_POS]; endproperty
	a_ev_clr: assert property (p_ev_clr) else $error("event not cleared");
	property p_framing; rd_su && ofs == OFS_EVENTS && pend_q
		|=> prdata[EV_FRAMING_POS]; endproperty
	a_framing: assert property (p_framing) else $error("framing change lost");
	property p_reinit_quiet; rd_su && ofs == OFS_VERSION && age_q == 3'h0
		|=> !prdata[REINIT_POS]; endproperty
	a_reinit_quiet: assert property (p_reinit_quiet) else $error("reinit without spike");
	property p_reinit_held; rd_su && ofs == OFS_VERSION && age_q == 3'h7
		|=> prdata[REINIT_POS]; endproperty
	a_reinit_held: assert property (p_reinit_held) else $error("reinit flag missing");
	property p_st_fix; rd_su && ofs == OFS_SUP_STATUS
		|=> (prdata & ~32'h20) == {24'h0, RST_SUP_STATUS}; endproperty
	a_st_fix: assert property (p_st_fix) else $error("status bits moved");
	property p_st_flag; rd_su && ofs == OFS_SUP_STATUS
		|=> prdata[SYNC_FLAG_POS] == sync_state_flag; endproperty
	a_st_flag: assert property (p_st_flag) else $error("sync bit and flag differ");
	property p_off; acc && pwrite && ofs == OFS_OP_MODE && !pwdata[SUPERVISE_EN_POS]
		|-> ##[1:20] !sync_state_flag; endproperty
	a_off: assert property (p_off) else $error("sync kept while off");
	property p_st_ok; acc && ofs == OFS_SUP_STATUS |-> !pslverr; endproperty
	a_st_ok: assert property (p_st_ok) else $error("status read refused");
endmodule // pcm_line_supervision_sva
bind pcm_line_supervision pcm_line_supervision_sva pcm_line_supervision_sva_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.mismatch_valid(mismatch_valid), .spike_detect(spike_detect),
	.sync_state_flag(sync_state_flag));

// ==== sim/tb.sv ====
/* Bench for the supervision block: mismatch decode table, framing,
   spikes and reset. Assumes the backplane model drives the link. */
`timescale 1ns/100ps
module tb import pcm_sup_pkg::*; ;
	// ==========================================================
	// Signals; DUT and model inputs given a value at time zero
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, mm_valid = 1'b0, spike = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, r;
	logic        pready, pslverr, bclk, fs, sync_flag, e;
	logic [11:0] frame_len = 12'd128;
	mismatch_s   mm_in = '0;
	int          miscompares = 0, compares = 0, nfs, fs_count = 0;
	typedef struct {logic [1:0] mode; logic [31:0] loc;} row_s; // Mode, expected location
	row_s rows[4] = '{'{2'd0, 32'h106}, '{2'd1, 32'h30d}, '{2'd2, 32'h70b}, '{2'd3, 32'h30d}};
	pcm_line_supervision #(.CNT_W(10)) pcm_line_supervision_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pcm_bit_clock(bclk), .frame_sync_pulse(fs), .mismatch_valid(mm_valid),
		.mismatch_in(mm_in), .spike_detect(spike), .sync_state_flag(sync_flag));
	pcm_backplane_model pcm_backplane_model_inst (.frame_len(frame_len),
		.pcm_bit_clock(bclk), .frame_sync_pulse(fs));
	always #50 pclk = ~pclk;
	// Frame starts counted on the link side; a pclk sample could miss the short pulse
	always @(posedge fs) fs_count++;
	// ==========================================================
	// Tasks
	task automatic chk(input string name, input logic [31:0] x, input logic [31:0] got);
		compares++;
		if (got !== x) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, x, got);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			give_verdict();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0);
		chk($sformatf("read %h", a), x, r);
		chk("pslverr", {31'h0, xe}, {31'h0, e});
	endtask
	task automatic mm(input logic p, input logic [6:0] c);
		@(posedge pclk);
		mm_valid <= 1'b1;
		mm_in <= '{pair: p, code: c};
		@(posedge pclk);
		mm_valid <= 1'b0;
	endtask
	// Bounded wait for the sync flag, counting frame starts
	task automatic wait_flag(input logic v);
		int n = 0;
		int start = fs_count;
		while (sync_flag !== v && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		nfs = fs_count - start;
		if (n >= 3000) begin
			chk("wait", 32'h0, 32'h1);
			give_verdict();
		end
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_VERSION, 32'h1000, 1'b0);
		apb(1'b1, OFS_BITS_FRAME, 32'h7f);
		apb(1'b1, OFS_OP_MODE, 32'h1);
		wait_flag(1'b1);
		rd(OFS_EVENTS, 32'h08, 1'b0);
		// pair enable set; known code pattern
		foreach (rows[i]) begin
			apb(1'b1, OFS_PCM_MODE, {24'h0, rows[i].mode, 4'h0, i == 2, i != 2});
			mm(i == 2, 7'h13);
			rd(OFS_EVENTS, 32'h04, 1'b0);
			rd(OFS_MISMATCH, {24'h0, i == 2, 7'h13}, 1'b0);
			rd(OFS_LOCATION, rows[i].loc, 1'b0);
		end
		$display("test decode done");
		mm(1'b0, 7'h13);
		mm(1'b0, 7'h22);
		rd(OFS_EVENTS, 32'h04, 1'b0);
		rd(OFS_EVENTS, 32'h0, 1'b0);
		rd(OFS_MISMATCH, 32'h13, 1'b0);
		mm(1'b1, 7'h22);
		rd(OFS_EVENTS, 32'h0, 1'b0);
		$display("test rearm done");
		apb(1'b1, OFS_PCM_MODE, 32'h21);
		wait_flag(1'b0);
		rd(OFS_EVENTS, 32'h08, 1'b0);
		frame_len = 12'd256;
		wait_flag(1'b1);
		chk("frames", 32'h1, {31'h0, nfs >= 2});
		frame_len = 12'd1024;
		wait_flag(1'b0);
		repeat (1500) @(posedge pclk);
		chk("sync", 32'h0, {31'h0, sync_flag});
		frame_len = 12'd256;
		wait_flag(1'b1);
		apb(1'b1, OFS_OP_MODE, 32'h0);
		wait_flag(1'b0);
		rd(OFS_SUP_STATUS, 32'h05, 1'b0);
		$display("test framing done");
		@(posedge pclk);
		spike <= 1'b1;
		@(posedge pclk);
		spike <= 1'b0;
		repeat (8) @(posedge pclk);
		rd(OFS_VERSION, 32'h1001, 1'b0);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_VERSION, 32'h1000, 1'b0);
		rd(OFS_SUP_STATUS, 32'h05, 1'b0);
		rd(OFS_PCM_MODE, 32'h0, 1'b0);
		rd(8'h20, 32'h0, 1'b1);
		$display("test reset done");
		give_verdict();
	end
endmodule // tb
